// ==== hw/lbs_pkg.sv ====
// package for the local bus slave wait timing block: state types,
// wait-state counts, strap layout and register map.
// assumes a single 100 MHz local clock; pci clock arrives as a pin.
package lbs_pkg;

   // wait states per kind of slave answer (cycles between start and end)
   localparam logic [2:0] LBS_W_RETRY     = 3'h1;
   localparam logic [2:0] LBS_W_BURST_WR  = 3'h1;
   localparam logic [2:0] LBS_W_POST_WR   = 3'h1;
   localparam logic [2:0] LBS_W_DLY       = 3'h2;
   localparam logic [2:0] LBS_W_DLY_BURST = 3'h1;
   localparam logic [2:0] LBS_W_REG_RD    = 3'h2;
   localparam logic [2:0] LBS_W_REG_WR    = 3'h5;
   localparam logic [1:0] LBS_REG_RETRY_MAX = 2'h2;

   // register port map
   localparam int         LBS_AW          = 4;
   localparam int         LBS_DW          = 16;
   localparam logic [3:0] LBS_REG_STATUS  = 4'h0;
   localparam logic [3:0] LBS_REG_CLEAR   = 4'h1;
   localparam logic [3:0] LBS_REG_ENABLE  = 4'h2;
   localparam logic [3:0] LBS_REG_STRAP   = 4'h3;
   localparam logic [3:0] LBS_REG_CTRL    = 4'h4;

   // status and control bit positions
   localparam int LBS_EV_RETRY = 0;
   localparam int LBS_EV_POST  = 1;
   localparam int LBS_EV_DLY   = 2;
   localparam int LBS_EV_STRAP = 3;
   localparam int LBS_NEV      = 4;
   localparam int LBS_CTRL_RST = 0;

   localparam logic [3:0] LBS_EV_RST   = 4'h0;
   localparam logic [8:0] LBS_STRAP_RST = 9'h000;

   typedef enum logic [2:0] {
      LBS_IDLE = 3'b001,
      LBS_WAIT = 3'b010,
      LBS_TERM = 3'b100
   } lbs_fsm_t;

   // reset-option inputs, caught at reset release or hot-swap ok
   typedef struct packed {
      logic       size1;
      logic [1:0] test_sel;
      logic       burst_n;
      logic       bm_allow;
      logic       sda;
      logic       id_en;
      logic       pci_side_disable;
      logic       arb_en;
   } lbs_strap_t;

   // processor-side cycle attributes sampled at start
   typedef struct packed {
      logic rd;
      logic burst;
      logic reg_sel;
      logic integrated_dma;
   } lbs_cyc_t;

endpackage

// ==== hw/lbs_slave.sv ====
// local bus slave response timing: wait-state insertion, register
// retry limit, reset-option capture, reset and interrupt pin pacing.
// assumes the processor runs on mclk; pci clock, pci reset, local reset
// in, hot-swap ok and strap pins are asynchronous and are synchronised.
//
// Behaviour
// - retried cycle gets one wait state
// - accepted burst write gets one wait state
// - posted single write gets one wait state
// - completed delayed single read/write: two waits
// - completed delayed burst read: one wait
// - integrated dma ignores these wait counts
// - register access retried at most two times
// - register read ack three clocks after start
// - register write ack six clocks after start
// - latch straps on local or pci reset release
// - also latch straps on hot-swap ok falling
// - reset out follows pci reset
// - other reset out changes on pci clock rise
// - interrupt pin changes on pci clock rise
`timescale 1ns/100ps
`default_nettype none

module lbs_slave
   import lbs_pkg::*;
(
   input  wire logic              mclk,
   input  wire logic              rst_n,
   // processor side
   input  wire logic              transfer_start_n,
   input  wire logic              address_strobe_n,
   input  wire lbs_cyc_t          cyc,
   output logic                   transfer_ack_n,
   output logic                   size_ack_n,
   output logic                   retry_n,
   // bridge core side
   input  wire logic              post_ok,
   input  wire logic              dly_ready,
   input  wire logic              reg_busy,
   output logic                   dly_req,
   // asynchronous pins
   input  wire logic              pci_clk_pin,
   input  wire logic              pci_rst_n,
   input  wire logic              local_reset_in_n,
   input  wire logic              hot_swap_ok_n,
   input  wire lbs_strap_t        strap_pins,
   output lbs_strap_t             strap,
   output logic                   local_reset_out_n_o,
   output logic                   local_reset_out_n_oe,
   output logic                   local_irq_n_o,
   output logic                   local_irq_n_oe,
   // register port
   input  wire logic [LBS_AW-1:0] reg_addr,
   input  wire logic [LBS_DW-1:0] reg_wdata,
   input  wire logic              reg_wr,
   input  wire logic              reg_rd,
   output logic [LBS_DW-1:0]      reg_rdata,
   output logic                   irq
);

   typedef struct packed {
      lbs_fsm_t             fsm;
      logic [2:0]           cnt;
      logic                 term_retry;
      logic [1:0]           rcnt;
      logic                 as_prev;
      logic [1:0]           pclk_sync;
      logic                 pclk_prev;
      logic [1:0]           prst_sync;
      logic                 prst_prev;
      logic [1:0]           lrst_sync;
      logic                 lrst_prev;
      logic [1:0]           hs_sync;
      logic                 hs_prev;
      lbs_strap_t           strap_s1;
      lbs_strap_t           strap_s2;
      lbs_strap_t           strap;
      logic [LBS_NEV-1:0]   status;
      logic [LBS_NEV-1:0]   enable;
      logic                 ctrl_rst;
      logic                 rst_oe;
      logic                 irq_oe;
      logic                 ack;
      logic                 retry;
      logic                 dly_req;
      logic [LBS_DW-1:0]    rdata;
   } lbs_state_t;

   lbs_state_t s_q;
   lbs_state_t s_d;

   logic       start;
   logic       reg_retry;
   logic       reg_ok;
   logic       pci_post;
   logic       pci_dly;
   logic       pci_retry;
   logic       go_retry;
   logic [2:0] waits;
   logic       pclk_rise;
   logic       prst_rise;
   logic       strap_ev;
   logic [LBS_NEV-1:0] ev;

   // wait states for a cycle that completes normally
   function automatic logic [2:0] lbs_done_waits(
      input logic rd,
      input logic burst,
      input logic is_reg,
      input logic is_post
   );
      logic [2:0] w;
      w = LBS_W_DLY;
      if (is_reg) begin
         w = rd ? LBS_W_REG_RD : LBS_W_REG_WR;
      end else if (is_post) begin
         w = burst ? LBS_W_BURST_WR : LBS_W_POST_WR;
      end else if (rd && burst) begin
         w = LBS_W_DLY_BURST;
      end
      return w;
   endfunction

   // cycle classification at the start cycle
   always_comb begin
      // address strobe is held for the cycle, so only its fall starts one
      start     = (s_q.fsm == LBS_IDLE) &&
                  (!transfer_start_n || (!address_strobe_n && s_q.as_prev));
      // busy register channel is retried, but never a third time
      reg_retry = cyc.reg_sel && !cyc.integrated_dma && reg_busy &&
                  (s_q.rcnt < LBS_REG_RETRY_MAX);
      reg_ok    = cyc.reg_sel && !cyc.integrated_dma && !reg_retry;
      pci_post  = !cyc.reg_sel && !cyc.integrated_dma && !cyc.rd && post_ok;
      pci_dly   = !cyc.reg_sel && !cyc.integrated_dma && !pci_post && dly_ready;
      pci_retry = !cyc.reg_sel && !cyc.integrated_dma && !pci_post && !dly_ready;
      go_retry  = reg_retry || pci_retry;
      if (go_retry) begin
         waits = LBS_W_RETRY;
      end else begin
         waits = lbs_done_waits(cyc.rd, cyc.burst, reg_ok, pci_post);
      end
   end

   // edges of synchronised pins; only second stages are looked at
   always_comb begin
      pclk_rise = s_q.pclk_sync[1] && !s_q.pclk_prev;
      prst_rise = s_q.prst_sync[1] && !s_q.prst_prev;
      strap_ev  = prst_rise ||
                  (s_q.lrst_sync[1] && !s_q.lrst_prev) ||
                  (!s_q.hs_sync[1] && s_q.hs_prev);
      ev = '0;
      ev[LBS_EV_RETRY] = start && !cyc.integrated_dma && go_retry;
      ev[LBS_EV_POST]  = start && pci_post;
      ev[LBS_EV_DLY]   = start && pci_dly;
      ev[LBS_EV_STRAP] = strap_ev;
   end

   // next state of the whole block
   always_comb begin
      s_d = s_q;
      s_d.as_prev   = address_strobe_n;
      s_d.pclk_sync = {s_q.pclk_sync[0], pci_clk_pin};
      s_d.pclk_prev = s_q.pclk_sync[1];
      s_d.prst_sync = {s_q.prst_sync[0], pci_rst_n};
      s_d.prst_prev = s_q.prst_sync[1];
      s_d.lrst_sync = {s_q.lrst_sync[0], local_reset_in_n};
      s_d.lrst_prev = s_q.lrst_sync[1];
      s_d.hs_sync   = {s_q.hs_sync[0], hot_swap_ok_n};
      s_d.hs_prev   = s_q.hs_sync[1];
      s_d.strap_s1  = strap_pins;
      s_d.strap_s2  = s_q.strap_s1;
      s_d.ack       = 1'b0;
      s_d.retry     = 1'b0;
      s_d.dly_req   = 1'b0;

      // straps caught on reset release or hot-swap ok
      if (strap_ev) begin
         s_d.strap = s_q.strap_s2;
      end

      // slave cycle sequencer: start, waits, one termination cycle
      case (s_q.fsm)
         LBS_IDLE: begin
            if (start) begin
               s_d.term_retry = go_retry;
               s_d.dly_req    = pci_retry;
               if (cyc.integrated_dma) begin
                  // dma keeps its own zero-wait timing
                  s_d.fsm   = LBS_IDLE;
                  s_d.ack   = 1'b1;
               end else begin
                  s_d.fsm = LBS_WAIT;
                  s_d.cnt = waits - 3'h1;
               end
               if (cyc.reg_sel && !cyc.integrated_dma) begin
                  s_d.rcnt = reg_retry ? s_q.rcnt + 2'h1 : 2'h0;
               end
            end
         end
         LBS_WAIT: begin
            if (s_q.cnt == 3'h0) begin
               s_d.fsm   = LBS_TERM;
               s_d.ack   = !s_q.term_retry;
               s_d.retry = s_q.term_retry;
            end else begin
               s_d.cnt = s_q.cnt - 3'h1;
            end
         end
         LBS_TERM: begin
            s_d.fsm = LBS_IDLE;
         end
         default: begin
            s_d.fsm = LBS_IDLE;
         end
      endcase

      // sticky status: an event in the clear cycle survives
      if (reg_wr && reg_addr == LBS_REG_CLEAR) begin
         s_d.status = s_q.status & ~reg_wdata[LBS_NEV-1:0];
      end
      s_d.status = s_d.status | ev;
      if (reg_wr && reg_addr == LBS_REG_ENABLE) begin
         s_d.enable = reg_wdata[LBS_NEV-1:0];
      end
      if (reg_wr && reg_addr == LBS_REG_CTRL) begin
         s_d.ctrl_rst = reg_wdata[LBS_CTRL_RST];
      end

      // register read data, valid the cycle after the strobe only
      s_d.rdata = '0;
      if (reg_rd) begin
         case (reg_addr)
            LBS_REG_STATUS: s_d.rdata[LBS_NEV-1:0] = s_q.status;
            LBS_REG_ENABLE: s_d.rdata[LBS_NEV-1:0] = s_q.enable;
            LBS_REG_STRAP:  s_d.rdata[8:0] = s_q.strap;
            LBS_REG_CTRL:   s_d.rdata[LBS_CTRL_RST] = s_q.ctrl_rst;
            default:        s_d.rdata = '0;
         endcase
      end

      // reset out: pci reset acts at once, software request on pclk
      if (!s_q.prst_sync[1]) begin
         s_d.rst_oe = 1'b1;
      end else if (prst_rise) begin
         s_d.rst_oe = 1'b0;
      end else if (pclk_rise) begin
         s_d.rst_oe = s_q.ctrl_rst;
      end

      // interrupt pin paced by the pci clock; pclk must be under mclk/2
      if (pclk_rise) begin
         s_d.irq_oe = |(s_q.status & s_q.enable);
      end
   end

   // single state register
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         s_q            <= '0;
         s_q.fsm        <= LBS_IDLE;
         s_q.as_prev    <= 1'b1;
         s_q.lrst_sync  <= 2'h3;   // idle level, so release is no edge
         s_q.lrst_prev  <= 1'b1;
         s_q.hs_sync    <= 2'h3;
         s_q.hs_prev    <= 1'b1;
         s_q.strap      <= LBS_STRAP_RST;
         s_q.status     <= LBS_EV_RST;
         s_q.enable     <= LBS_EV_RST;
      end else begin
         s_q <= s_d;
      end
   end

   // pins and ports
   assign transfer_ack_n       = !s_q.ack;
   assign size_ack_n           = !s_q.ack;
   assign retry_n              = !s_q.retry;
   assign dly_req              = s_q.dly_req;
   assign strap                = s_q.strap;
   assign local_reset_out_n_o  = 1'b0;   // open drain: drives low only
   assign local_reset_out_n_oe = s_q.rst_oe;
   assign local_irq_n_o        = 1'b0;
   assign local_irq_n_oe       = s_q.irq_oe;
   assign reg_rdata            = s_q.rdata;
   assign irq                  = |(s_q.status & s_q.enable);

   // checks on the answer timing, strap capture and pin pacing
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!rst_n);

   a_retry_wait: assert property (
      start && !cyc.integrated_dma && go_retry |->
         ##1 (retry_n && transfer_ack_n) ##1 (!retry_n && transfer_ack_n))
      else $error("retry not after exactly one wait state");

   a_burst_wr_wait: assert property (
      start && pci_post && cyc.burst |->
         ##1 transfer_ack_n ##1 !transfer_ack_n)
      else $error("burst write ack not after one wait state");

   a_post_wr_wait: assert property (
      start && pci_post && !cyc.burst |->
         ##1 transfer_ack_n ##1 (!transfer_ack_n && retry_n))
      else $error("posted write ack not after one wait state");

   a_dly_single_wait: assert property (
      start && pci_dly && !(cyc.rd && cyc.burst) |->
         ##1 transfer_ack_n [*2] ##1 !transfer_ack_n)
      else $error("delayed completion ack not after two waits");

   a_dly_burst_wait: assert property (
      start && pci_dly && cyc.rd && cyc.burst |->
         ##1 transfer_ack_n ##1 !transfer_ack_n)
      else $error("delayed burst read ack not after one wait");

   a_integrated_dma_no_wait: assert property (
      start && cyc.integrated_dma |-> ##1 (!transfer_ack_n && retry_n))
      else $error("dma cycle not answered in the next cycle");

   a_reg_retry_cap: assert property (
      start && cyc.reg_sel && !cyc.integrated_dma &&
      s_q.rcnt == LBS_REG_RETRY_MAX |-> ##1 retry_n [*3])
      else $error("register access retried a third time");

   a_reg_rd_lat: assert property (
      start && reg_ok && cyc.rd |->
         ##1 transfer_ack_n [*2] ##1 !transfer_ack_n)
      else $error("register read ack not three clocks after start");

   a_reg_wr_lat: assert property (
      start && reg_ok && !cyc.rd |->
         ##1 transfer_ack_n [*5] ##1 !transfer_ack_n)
      else $error("register write ack not six clocks after start");

   a_strap_on_rst: assert property (
      prst_rise |=> strap == $past(s_q.strap_s2))
      else $error("straps not caught at pci reset release");

   a_strap_on_hs: assert property (
      !s_q.hs_sync[1] && s_q.hs_prev |=> strap == $past(s_q.strap_s2))
      else $error("straps not caught at hot-swap ok fall");

   a_rst_follow: assert property (
      !s_q.prst_sync[1] |=> local_reset_out_n_oe)
      else $error("reset out not driven during pci reset");

   a_rst_pclk: assert property (
      $changed(local_reset_out_n_oe) && $past(s_q.prst_sync[1]) &&
      !$past(prst_rise) |-> $past(pclk_rise))
      else $error("reset out changed off a pci clock rise");

   a_irq_pclk: assert property (
      $changed(local_irq_n_oe) |-> $past(pclk_rise))
      else $error("interrupt pin changed off a pci clock rise");

   a_term_one: assert property (
      !transfer_ack_n && s_q.fsm == LBS_TERM |=> transfer_ack_n)
      else $error("termination held for more than one cycle");

endmodule

`default_nettype wire

// ==== verif/lbs_cpu_model.sv ====
// local processor model: runs one slave cycle per request and
// reports the cycle in which the slave ended it.
// assumes the slave sits on the same mclk.
`timescale 1ns/100ps
`default_nettype none

module lbs_cpu_model
   import lbs_pkg::*;
(
   input  wire logic     mclk,
   input  wire logic     rst_n,
   input  wire logic     go,
   input  wire lbs_cyc_t go_cyc,
   input  wire logic     use_as,
   input  wire logic     transfer_ack_n,
   input  wire logic     retry_n,
   output logic          transfer_start_n,
   output logic          address_strobe_n,
   output lbs_cyc_t      cyc,
   output logic          busy,
   output logic          got_retry,
   output logic [3:0]    lat
);
   logic [3:0] cnt;

   // attributes stand until the ending edge, then are scrambled so a
   // stale value can never pass for a held one
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         transfer_start_n <= 1'b1;
         address_strobe_n <= 1'b1;
         cyc              <= '0;
         busy             <= 1'b0;
         got_retry        <= 1'b0;
         lat              <= 4'h0;
         cnt              <= 4'h0;
      end else if (go && !busy) begin
         busy             <= 1'b1;
         cnt              <= 4'h0;
         cyc              <= go_cyc;
         transfer_start_n <= use_as;
         address_strobe_n <= !use_as;
      end else if (busy) begin
         transfer_start_n <= 1'b1;
         if (!transfer_ack_n || !retry_n) begin
            busy             <= 1'b0;
            lat              <= cnt;
            got_retry        <= !retry_n;
            address_strobe_n <= 1'b1;
            cyc              <= ~cyc;
         end else begin
            cnt <= cnt + 4'h1;
         end
      end
   end
endmodule
`default_nettype wire

// ==== verif/testbench.sv ====
// self-checking bench for lbs_slave: cycle timing, register port,
// interrupt and reset pins, strap capture.
// assumes lbs_cpu_model plays the processor on the far side.
`timescale 1ns/100ps
`default_nettype none

module testbench;
   import lbs_pkg::*;
   logic        mclk = 0, rst_n = 0, go = 0, use_as = 0, pci_run = 0;
   logic        post_ok = 0, dly_ready = 0, reg_busy = 0, pci_clk_pin = 0;
   logic        pci_rst_n = 0, local_reset_in_n = 1, hot_swap_ok_n = 1;
   logic        reg_wr = 0, reg_rd = 0, irq, busy, got_retry;
   logic        transfer_start_n, address_strobe_n, transfer_ack_n;
   logic        size_ack_n, retry_n, lro_oe, irq_oe;
   logic        lro_o, irq_o, dly_req;
   logic [3:0]  reg_addr = 4'h0, lat;
   logic [15:0] reg_wdata = 16'h0000, reg_rdata;
   lbs_cyc_t    go_cyc = '0, cyc;
   lbs_strap_t  strap_pins = '0, strap;
   int          n_errors = 0, n_tests = 0;
   int          n_sack = 0, n_dly = 0;

   always #5 mclk = ~mclk;

   // size acknowledge and delayed-request pulses over the whole run
   always @(posedge mclk) begin
      if (size_ack_n === 1'b0)
         n_sack++;
      if (dly_req === 1'b1)
         n_dly++;
   end

   // pci clock near 33 MHz, off the mclk edges, frozen when not wanted
   initial begin
      #3;
      forever begin
         #15;
         if (pci_run)
            pci_clk_pin = ~pci_clk_pin;
      end
   end

   lbs_slave i_dut (.mclk(mclk), .rst_n(rst_n),
      .transfer_start_n(transfer_start_n),
      .address_strobe_n(address_strobe_n), .cyc(cyc),
      .transfer_ack_n(transfer_ack_n), .size_ack_n(size_ack_n),
      .retry_n(retry_n), .post_ok(post_ok), .dly_ready(dly_ready),
      .reg_busy(reg_busy), .dly_req(dly_req), .pci_clk_pin(pci_clk_pin),
      .pci_rst_n(pci_rst_n), .local_reset_in_n(local_reset_in_n),
      .hot_swap_ok_n(hot_swap_ok_n), .strap_pins(strap_pins),
      .strap(strap), .local_reset_out_n_o(lro_o),
      .local_reset_out_n_oe(lro_oe), .local_irq_n_o(irq_o),
      .local_irq_n_oe(irq_oe), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .irq(irq));

   lbs_cpu_model i_cpu (.mclk(mclk), .rst_n(rst_n), .go(go),
      .go_cyc(go_cyc), .use_as(use_as),
      .transfer_ack_n(transfer_ack_n), .retry_n(retry_n),
      .transfer_start_n(transfer_start_n),
      .address_strobe_n(address_strobe_n), .cyc(cyc), .busy(busy),
      .got_retry(got_retry), .lat(lat));

   task automatic end_of_test();
      $display("checks %0d mismatches %0d", n_tests, n_errors);
      if (n_errors == 0 && n_tests > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   task automatic chk(input string what, input logic [15:0] exp,
                      input logic [15:0] got);
      n_tests++;
      if (got !== exp) begin
         n_errors++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge mclk);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_wr    <= 1'b1;
      @(posedge mclk);
      reg_wr <= 1'b0;
      #1;
   endtask

   // read data stand only in the cycle after the strobe
   task automatic rd(input logic [3:0] a, input logic [15:0] exp);
      @(posedge mclk);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      @(posedge mclk);
      reg_rd <= 1'b0;
      #1;
      chk($sformatf("register %h", a), exp, reg_rdata);
   endtask

   function automatic logic pin(input int k);
      return (k == 0) ? lro_oe : irq_oe;
   endfunction

   // bounded wait for a pci-paced pin
   task automatic wait_pin(input int k, input logic v);
      for (int i = 0; i < 40 && pin(k) !== v; i++)
         @(posedge mclk);
      #1;
   endtask

   // one slave cycle; ctl is {post_ok, dly_ready, reg_busy}
   task automatic run(input logic [3:0] c, input logic [2:0] ctl,
                      input logic a, input logic [3:0] xl,
                      input logic xr);
      @(posedge mclk);
      go     <= 1'b1;
      go_cyc <= c;
      use_as <= a;
      {post_ok, dly_ready, reg_busy} <= ctl;
      @(posedge mclk);
      go <= 1'b0;
      #1;
      for (int i = 0; i < 20 && busy !== 1'b0; i++)
         @(posedge mclk);
      #1;
      chk($sformatf("end cycle of %h", c), {12'h000, xl}, {12'h000, lat});
      chk($sformatf("retry of %h", c), {15'h0000, xr}, {15'h0000, got_retry});
      repeat (8) @(posedge mclk);
      $display("cycle test %h done", c);
   endtask

   initial begin
      #100000;
      n_errors++;
      $display("ERROR watchdog expected done seen hang");
      end_of_test();
   end

   initial begin
      repeat (8) @(posedge mclk);
      rst_n <= 1'b1;
      wait_pin(0, 1'b1);
      chk("reset out in pci reset", 16'h0001, {15'h0000, lro_oe});
      chk("reset out level", 16'h0000, {15'h0000, lro_o});
      rd(LBS_REG_ENABLE, 16'h0000);
      rd(LBS_REG_CTRL, 16'h0000);
      wr(4'hF, 16'hFFFF);
      rd(4'hF, 16'h0000);
      // straps held at least 5 clocks either side of each capture edge
      @(posedge mclk);
      strap_pins <= 9'h1A5;
      repeat (5) @(posedge mclk);
      pci_rst_n <= 1'b1;
      wait_pin(0, 1'b0);
      chk("reset out release", 16'h0000, {15'h0000, lro_oe});
      repeat (6) @(posedge mclk);
      chk("strap pci", 16'h01A5, {7'h00, strap});
      rd(LBS_REG_STRAP, 16'h01A5);
      @(posedge mclk);
      strap_pins <= 9'h05A;
      repeat (5) @(posedge mclk);
      local_reset_in_n <= 1'b0;
      repeat (5) @(posedge mclk);
      local_reset_in_n <= 1'b1;
      repeat (8) @(posedge mclk);
      chk("strap local", 16'h005A, {7'h00, strap});
      strap_pins <= 9'h133;
      repeat (5) @(posedge mclk);
      hot_swap_ok_n <= 1'b0;
      repeat (8) @(posedge mclk);
      chk("strap hot swap", 16'h0133, {7'h00, strap});
      rd(LBS_REG_STATUS, 16'h0008);
      wr(LBS_REG_CLEAR, 16'h000F);
      rd(LBS_REG_STATUS, 16'h0000);
      $display("strap test done");
      // slave cycle timing, one wait state is one extra clock
      run(4'h0, 3'h4, 1'b0, 4'h2, 1'b0);
      run(4'h4, 3'h4, 1'b0, 4'h2, 1'b0);
      run(4'h8, 3'h0, 1'b0, 4'h2, 1'b1);
      run(4'h8, 3'h2, 1'b0, 4'h3, 1'b0);
      run(4'h0, 3'h2, 1'b0, 4'h3, 1'b0);
      run(4'hC, 3'h2, 1'b0, 4'h2, 1'b0);
      run(4'h9, 3'h3, 1'b0, 4'h1, 1'b0);
      run(4'hA, 3'h1, 1'b0, 4'h2, 1'b1);
      run(4'hA, 3'h1, 1'b0, 4'h2, 1'b1);
      run(4'hA, 3'h1, 1'b0, 4'h3, 1'b0);
      run(4'h2, 3'h0, 1'b1, 4'h6, 1'b0);
      run(4'hA, 3'h0, 1'b1, 4'h3, 1'b0);
      run(4'hA, 3'h1, 1'b0, 4'h2, 1'b1);
      rd(LBS_REG_STATUS, 16'h0007);
      // nine cycles ended by acknowledge, one pci-space retry
      chk("size acks", 16'h0009, 16'(n_sack));
      chk("delayed requests", 16'h0001, 16'(n_dly));
      wr(LBS_REG_STATUS, 16'h0000);
      rd(LBS_REG_STATUS, 16'h0007);
      // pins must not move while the pci clock stands still
      wr(LBS_REG_ENABLE, 16'h0002);
      chk("irq level", 16'h0001, {15'h0000, irq});
      rd(LBS_REG_ENABLE, 16'h0002);
      wr(LBS_REG_CTRL, 16'h0001);
      repeat (20) @(posedge mclk);
      chk("irq pin frozen", 16'h0000, {15'h0000, irq_oe});
      chk("reset out frozen", 16'h0000, {15'h0000, lro_oe});
      pci_run <= 1'b1;
      wait_pin(1, 1'b1);
      chk("irq pin", 16'h0001, {15'h0000, irq_oe});
      chk("irq pin level", 16'h0000, {15'h0000, irq_o});
      wait_pin(0, 1'b1);
      chk("reset out soft", 16'h0001, {15'h0000, lro_oe});
      wr(LBS_REG_CLEAR, 16'h0002);
      chk("irq masked", 16'h0000, {15'h0000, irq});
      rd(LBS_REG_STATUS, 16'h0005);
      wait_pin(1, 1'b0);
      chk("irq pin off", 16'h0000, {15'h0000, irq_oe});
      wr(LBS_REG_CTRL, 16'h0000);
      wait_pin(0, 1'b0);
      chk("reset out off", 16'h0000, {15'h0000, lro_oe});
      $display("pin test done");
      end_of_test();
   end
endmodule
`default_nettype wire
